// file: vmr_pkg.sv
/*
  Constants, field layouts and types for the margin, user identity and
  DC sense divider register bank.
  Assumes: shared by the bank and by whatever joins it to the core.
*/
package vmr_pkg;

  // ****************************************************************
  // Command codes of the bank
  // ****************************************************************
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW  = 8'h26;
  localparam logic [7:0] CMD_MAKER       = 8'h27;
  localparam logic [7:0] CMD_PART        = 8'h28;
  localparam logic [7:0] CMD_REVISION    = 8'h29;
  localparam logic [7:0] CMD_DIV_SETUP   = 8'h2A;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int VID_W        = 9;
  localparam int ID_W         = 8;
  localparam int SETUP_W      = 14;
  localparam int FB_SRC_BIT   = 13;
  localparam int REF_PREC_BIT = 12;
  localparam int AMP_GAIN_BIT = 11;
  localparam int ADC_GAIN_HI  = 10;
  localparam int ADC_GAIN_LO  = 9;
  localparam int SCALE_HI     = 8;

  // ****************************************************************
  // Reset values (no documented value, all clear)
  // ****************************************************************
  localparam logic [8:0]  RST_MARGIN = 9'h000;
  localparam logic [7:0]  RST_ID     = 8'h00;
  localparam logic [13:0] RST_SETUP  = 14'h0000;

  // ****************************************************************
  // Scaling: VID lsb and amplifier limits
  // ****************************************************************
  localparam int VID_LSB_UV       = 6250;
  localparam int LIMIT_UNITY_UV   = 1600000;
  localparam int LIMIT_HALF_UV    = 3193750;
  localparam logic [8:0] VID_LIM_UNITY =
    9'(LIMIT_UNITY_UV / VID_LSB_UV);
  localparam logic [8:0] VID_LIM_HALF =
    9'(LIMIT_HALF_UV / VID_LSB_UV);
  localparam logic [21:0] STEP_UNITY_NV = 22'h17D784; // 1.5625 mV
  localparam logic [21:0] STEP_HALF_NV  = 22'h2FAF08; // 3.125 mV
  localparam int SCALE_UNITY = 32;  // Scale code for a 1:1 divider

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    VMR_OP_NOMINAL = 2'h0,
    VMR_OP_MLOW    = 2'h1,
    VMR_OP_MHIGH   = 2'h3
  } vmr_op_e;

  typedef enum logic [1:0] {
    VMR_ADC_HALF    = 2'h0,
    VMR_ADC_UNITY   = 2'h1,
    VMR_ADC_3Q      = 2'h2,
    VMR_ADC_INVALID = 2'h3
  } vmr_adc_e;

endpackage : vmr_pkg

// file: vmr_regs.sv
/*
  Margin target, user identity and DC sense divider register bank,
  with the derived reference target and sense path selections.
  Assumes: command, strobes and operating inputs come from core logic
  on ref_clk; the transaction layer decodes the bus in front of it.
*/
// How it works
// - In margin high the reference follows the 9-bit high target.
// - In margin low the reference follows the 9-bit low target.
// - Reserved upper bits are dropped on write and read as zero.
// - The 8-bit user maker code can be written and read back.
// - The 8-bit user part code can be written and read back.
// - The 8-bit configuration file revision is read/write.
// - Setup bit 13 picks divider feedback or remote differential sense.
// - Setup bit 12 keeps or drops the 2-bit reference fraction.
// - Amp gain 0 is unity, output limited to 1.6 V, 1.5625 mV steps.
// - Amp gain 1 is half, output up to 3.19375 V, 3.125 mV steps.
// - Bits 10:9 pick ADC sense gain half, unity or three-quarter.
// - Half amplifier gain forces the ADC sense gain to half.
// - Bits 8:0 hold the divider scale factor, 32 times the ratio.
// - A target below the minimum voltage setting is raised to it, but never above the amplifier limit.
`timescale 1ns/100ps
module vmr_regs
  import vmr_pkg::*;
(
  input  wire logic        ref_clk,        // Core clock, 25 MHz
  input  wire logic        sys_rst,        // Sync reset, high
  input  wire logic        wr_en,          // Write strobe
  input  wire logic        rd_en,          // Read strobe
  input  wire logic [7:0]  cmd,            // Command code
  input  wire logic [15:0] wr_data,        // Write word
  input  wire logic [1:0]  op_mode,        // Operating mode
  input  wire logic [8:0]  nominal_vid,    // Nominal target
  input  wire logic [8:0]  minimum_voltage_setting, // Floor, VID
  output logic      [15:0] rd_data_q,      // Read word
  output logic             rd_valid_q,     // Read answer pulse
  output logic             rd_err_q,       // Unmapped access pulse
  output logic      [8:0]  vref_target_q,  // Reference target, VID
  output logic             dc_feedback_source_sel_q,   // 1: remote
  output logic             dc_reference_precision_sel_q, // 1: coarse
  output logic             remote_amp_gain_sel_q,      // 1: half
  output logic      [1:0]  adc_sense_gain_q,           // Applied gain
  output logic      [8:0]  divider_scale_factor_q,     // Scale code
  output logic      [21:0] dc_step_nv_q    // Regulation step, nV
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [8:0]  mhigh;
    logic [8:0]  mlow;
    logic [7:0]  maker;
    logic [7:0]  part;
    logic [7:0]  rev;
    logic [13:0] setup;
    logic [15:0] rdata;
    logic        rvalid;
    logic        rerr;
    logic [8:0]  vref;
    logic        fb_sel;
    logic        ref_prec;
    logic        amp_gain;
    logic [1:0]  adc_gain;
    logic [8:0]  scale;
    logic [21:0] step;
  } vmr_state_s;

  vmr_state_s q;
  vmr_state_s d;
  logic [8:0] tgt;
  logic [8:0] lim;
  logic       hit;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Register writes, reads and derived controls
  always_comb begin
    d        = q;
    d.rvalid = 1'b0;
    d.rerr   = 1'b0;
    d.rdata  = 16'h0000;
    hit      = 1'b1;
    if (wr_en) begin
      case (cmd)
        CMD_MARGIN_HIGH: d.mhigh = wr_data[VID_W-1:0];
        CMD_MARGIN_LOW:  d.mlow  = wr_data[VID_W-1:0];
        CMD_MAKER:       d.maker = wr_data[ID_W-1:0];
        CMD_PART:        d.part  = wr_data[ID_W-1:0];
        CMD_REVISION:    d.rev   = wr_data[ID_W-1:0];
        CMD_DIV_SETUP:   d.setup = wr_data[SETUP_W-1:0];
        default:         hit     = 1'b0;
      endcase
    end
    // read returns stored value, no side effect
    if (rd_en && !wr_en) begin
      d.rvalid = 1'b1;
      case (cmd)
        CMD_MARGIN_HIGH: d.rdata = {7'h00, q.mhigh};
        CMD_MARGIN_LOW:  d.rdata = {7'h00, q.mlow};
        CMD_MAKER:       d.rdata = {8'h00, q.maker};
        CMD_PART:        d.rdata = {8'h00, q.part};
        CMD_REVISION:    d.rdata = {8'h00, q.rev};
        CMD_DIV_SETUP:   d.rdata = {2'h0, q.setup};
        default:         hit     = 1'b0;
      endcase
    end
    // Unmapped command answers zero with an error pulse
    d.rerr = (wr_en || rd_en) && !hit;

    d.fb_sel   = d.setup[FB_SRC_BIT];
    d.ref_prec = d.setup[REF_PREC_BIT];
    d.amp_gain = d.setup[AMP_GAIN_BIT];
    d.scale    = d.setup[SCALE_HI:0];
    // half amp gain forces half ADC gain
    if (d.amp_gain) begin
      d.adc_gain = VMR_ADC_HALF;
    end else begin
      // invalid code falls back to half as the safe choice
      case (d.setup[ADC_GAIN_HI:ADC_GAIN_LO])
        VMR_ADC_UNITY: d.adc_gain = VMR_ADC_UNITY;
        VMR_ADC_3Q:    d.adc_gain = VMR_ADC_3Q;
        default:       d.adc_gain = VMR_ADC_HALF;
      endcase
    end
    // unity limit and step; half limit and step
    lim    = d.amp_gain ? VID_LIM_HALF : VID_LIM_UNITY;
    d.step = d.amp_gain ? STEP_HALF_NV : STEP_UNITY_NV;

    // margin high / margin low target choice
    case (op_mode)
      VMR_OP_MHIGH: tgt = d.mhigh;
      VMR_OP_MLOW:  tgt = d.mlow;
      default:      tgt = nominal_vid;
    endcase
    if (tgt < minimum_voltage_setting) begin
      tgt = minimum_voltage_setting;
    end
    // Amplifier range wins over the floor, it protects the sense input
    if (tgt > lim) begin
      tgt = lim;
    end
    d.vref = tgt;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Whole state in one register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q          <= '0;
      q.mhigh    <= RST_MARGIN;
      q.mlow     <= RST_MARGIN;
      q.maker    <= RST_ID;
      q.part     <= RST_ID;
      q.rev      <= RST_ID;
      q.setup    <= RST_SETUP;
      q.step     <= STEP_UNITY_NV;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign rd_data_q                    = q.rdata;
  assign rd_valid_q                   = q.rvalid;
  assign rd_err_q                     = q.rerr;
  assign vref_target_q                = q.vref;
  assign dc_feedback_source_sel_q     = q.fb_sel;
  assign dc_reference_precision_sel_q = q.ref_prec;
  assign remote_amp_gain_sel_q        = q.amp_gain;
  assign adc_sense_gain_q             = q.adc_gain;
  assign divider_scale_factor_q       = q.scale;
  assign dc_step_nv_q                 = q.step;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // high target applied
  AST_MARGIN_HIGH: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (op_mode == VMR_OP_MHIGH && !wr_en && !q.amp_gain
     && q.mhigh >= minimum_voltage_setting && q.mhigh <= VID_LIM_UNITY)
    |=> vref_target_q == $past(q.mhigh))
    else $error("margin high target not applied");

  AST_MARGIN_LOW: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (op_mode == VMR_OP_MLOW && !wr_en && !q.amp_gain
     && q.mlow >= minimum_voltage_setting && q.mlow <= VID_LIM_UNITY)
    |=> vref_target_q == $past(q.mlow))
    else $error("margin low target not applied");

  AST_RSVD_ZERO: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_en && cmd == CMD_MARGIN_HIGH) ##1 (rd_en && !wr_en
     && cmd == CMD_MARGIN_HIGH) |=> rd_data_q[15:9] == 7'h00
     && rd_data_q[8:0] == $past(wr_data[8:0], 2))
    else $error("margin read back wrong or reserved bits set");

  AST_MAKER_RW: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_en && cmd == CMD_MAKER) ##1 (rd_en && !wr_en && cmd == CMD_MAKER)
    |=> rd_valid_q && rd_data_q == {8'h00, $past(wr_data[7:0], 2)})
    else $error("maker code read back wrong");

  AST_PART_RW: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_en && cmd == CMD_PART) ##1 (rd_en && !wr_en && cmd == CMD_PART)
    |=> rd_data_q == {8'h00, $past(wr_data[7:0], 2)})
    else $error("part code read back wrong");

  AST_REV_RW: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_en && cmd == CMD_REVISION)
    |=> q.rev == $past(wr_data[7:0]))
    else $error("revision not stored");

  AST_FB_SEL: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_en && cmd == CMD_DIV_SETUP)
    |=> dc_feedback_source_sel_q == $past(wr_data[13])
     && dc_reference_precision_sel_q == $past(wr_data[12])
     && divider_scale_factor_q == $past(wr_data[8:0]))
    else $error("setup controls not applied");

  AST_UNITY_RANGE: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !remote_amp_gain_sel_q |-> vref_target_q <= VID_LIM_UNITY
     && dc_step_nv_q == STEP_UNITY_NV)
    else $error("unity gain range or step wrong");

  AST_UNITY_CUT: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (op_mode == VMR_OP_MHIGH && !wr_en && !q.amp_gain
     && q.mhigh > VID_LIM_UNITY)
    |=> vref_target_q == VID_LIM_UNITY)
    else $error("unity gain target not cut at limit");

  AST_HALF_STEP: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    remote_amp_gain_sel_q |-> dc_step_nv_q == STEP_HALF_NV)
    else $error("half gain step wrong");

  AST_HALF_RANGE: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (op_mode == VMR_OP_MHIGH && !wr_en && q.amp_gain
     && q.mhigh >= minimum_voltage_setting)
    |=> vref_target_q == $past(q.mhigh))
    else $error("half gain target not applied");

  AST_ADC_GAIN: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_en && cmd == CMD_DIV_SETUP && !wr_data[11] && wr_data[10:9] != 2'h3)
    |=> adc_sense_gain_q == $past(wr_data[10:9]))
    else $error("adc gain not applied");

  AST_HALF_FORCE: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    remote_amp_gain_sel_q |-> adc_sense_gain_q == VMR_ADC_HALF)
    else $error("adc gain not forced to half");

  AST_FLOOR: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (minimum_voltage_setting <= VID_LIM_UNITY)
    |=> vref_target_q >= $past(minimum_voltage_setting))
    else $error("target below minimum");

  AST_READ_SAFE: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (rd_en && !wr_en) |=> $stable(q.setup) && $stable(q.mhigh)
     && $stable(q.maker))
    else $error("read altered register");

  AST_READ_ANSWER: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (rd_en && !wr_en) |=> rd_valid_q)
    else $error("read not answered");

  AST_READ_DROP: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!rd_en || wr_en) |=> !rd_valid_q && rd_data_q == 16'h0000)
    else $error("answer without accepted read");

endmodule : vmr_regs

// file: vmr_host.sv
/*
  Host side model of the bank's register port, one access a cycle.
  Assumes: a single caller steps it on ref_clk rising edges.
*/
`timescale 1ns/100ps
module vmr_host (
  input  wire logic        ref_clk, // Core clock
  output logic             wr_en,   // Write strobe
  output logic             rd_en,   // Read strobe
  output logic      [7:0]  cmd,     // Command code
  output logic      [15:0] wr_data  // Write word
);
  // ****************************************************************
  // Port drive
  // ****************************************************************
  // Quiet port at time zero
  initial begin
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    cmd     = 8'h00;
    wr_data = 16'h0000;
  end

  // One request per edge; idle lines flip so no stale word lingers
  task automatic acc(input logic w, r, input logic [7:0] c,
                     input logic [15:0] d);
    @(posedge ref_clk);
    wr_en <= w;
    rd_en <= r;
    if (w || r) begin
      cmd     <= c;
      wr_data <= d;
    end else begin
      cmd     <= ~cmd;
      wr_data <= ~wr_data;
    end
  endtask : acc
endmodule : vmr_host

// file: vmr_regs_tb.sv
/*
  Self-checking bench for the margin, identity and divider bank.
  Assumes: the host model drives the register port, the bench the
  operating inputs; expected read words queue up in issue order.
*/
`timescale 1ns/100ps
module vmr_regs_tb
  import vmr_pkg::*;
;
  logic        ref_clk, sys_rst, wr_en, rd_en, rd_valid_q, rd_err_q;
  logic [7:0]  cmd;
  logic [15:0] wr_data, rd_data_q, d;
  logic [1:0]  op_mode, adc_sense_gain_q;
  logic [8:0]  nominal_vid, floor_vid, vref_target_q, scale_q;
  logic        fb_q, prec_q, amp_q;
  logic [21:0] step_q;
  logic [16:0] exp_q[$];  // Expected {err, word} per read
  logic [16:0] ex;
  logic [15:0] img[6];    // Expected register image
  int          bad_count, n_compared, seed;

  vmr_host i_host (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en),
                   .cmd(cmd), .wr_data(wr_data));
  vmr_regs i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_en(wr_en),
    .rd_en(rd_en), .cmd(cmd), .wr_data(wr_data), .op_mode(op_mode),
    .nominal_vid(nominal_vid), .minimum_voltage_setting(floor_vid),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .rd_err_q(rd_err_q),
    .vref_target_q(vref_target_q), .dc_feedback_source_sel_q(fb_q),
    .dc_reference_precision_sel_q(prec_q), .remote_amp_gain_sel_q(amp_q),
    .adc_sense_gain_q(adc_sense_gain_q), .divider_scale_factor_q(scale_q),
    .dc_step_nv_q(step_q));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Kept bits per register: margins 9, ids 8, setup 14
  function automatic logic [15:0] msk(input int i);
    return (i < 2) ? 16'h01FF : (i < 5) ? 16'h00FF : 16'h3FFF;
  endfunction : msk

  // Target: chosen by mode, raised to floor, cut at the unity limit under unity amp gain
  function automatic logic [8:0] tgt(input logic [1:0] op,
                                     input logic [8:0] nv, fl);
    logic [8:0] t;
    t = (op == 2'h3) ? img[0][8:0] : (op == 2'h1) ? img[1][8:0] : nv;
    if (t < fl) t = fl;
    if (!img[5][11] && t > 9'h100) t = 9'h100;
    return t;
  endfunction : tgt

  task automatic chk(input logic [31:0] got, want, input string what);
    n_compared++;
    if (got !== want) begin
      bad_count++;
      $display("BAD %0t %s got %0h want %0h", $time, what, got, want);
    end
  endtask : chk

  task automatic wr(input int i, input logic [15:0] v);
    i_host.acc(1'b1, 1'b0, CMD_MARGIN_HIGH + 8'(i), v);
    img[i] = v & msk(i);
  endtask : wr

  task automatic rd(input int i);
    exp_q.push_back({1'b0, img[i]});
    i_host.acc(1'b0, 1'b1, CMD_MARGIN_HIGH + 8'(i), 16'h0000);
  endtask : rd

  task automatic idle();
    i_host.acc(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask : idle

  task automatic complete_run();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // Read answer monitor
  // ****************************************************************
  // Mid-cycle sampling keeps clear of the register update edge
  always @(negedge ref_clk) begin
    if (rd_valid_q === 1'b1) begin
      chk(exp_q.size() > 0, 1, "answer without request");
      if (exp_q.size() > 0) begin
        ex = exp_q.pop_front();
        chk({rd_err_q, rd_data_q}, ex, "read word");
      end
    end
  end

  // Hang guard, a few times the expected run
  initial begin
    #40000;
    bad_count++;
    complete_run();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 58737;
    bad_count = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    op_mode = 2'h0;
    nominal_vid = 9'h000;
    floor_vid = 9'h000;
    for (int i = 0; i < 6; i++) img[i] = 16'h0000;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Cleared after reset, read back to back
    for (int i = 0; i < 6; i++) rd(i);
    // Unmapped read answers zero with error, unmapped write gets an error pulse but no answer
    exp_q.push_back(17'h10000);
    i_host.acc(1'b0, 1'b1, 8'h24, 16'h0000);
    i_host.acc(1'b1, 1'b0, 8'h2B, 16'hFFFF);
    idle();
    @(negedge ref_clk);
    chk({rd_valid_q, rd_err_q}, 2'h1, "unmapped write");
    // Reserved bits set on every write, back-to-back read back
    for (int n = 0; n < 3; n++) begin
      for (int i = 0; i < 6; i++) begin
        wr(i, 16'($random(seed)) | ~msk(i));
        // First pass reads each word straight after its write
        if (n == 0) rd(i);
      end
      for (int i = 0; i < 6; i++) rd(i);
    end
    // Read beside a write is dropped, the write lands
    i_host.acc(1'b1, 1'b1, CMD_MAKER, 16'hA55A);
    img[2] = 16'h005A;
    rd(2);
    // Every amp gain and ADC code
    for (int a = 0; a < 8; a++) begin
      d = {2'h3, 2'($random(seed)), 3'(a), 9'($random(seed))};
      wr(5, d);
      idle();
      @(negedge ref_clk);
      chk(fb_q, d[13], "feedback source");
      chk(prec_q, d[12], "precision");
      chk(amp_q, d[11], "amp gain");
      chk(adc_sense_gain_q, (d[11] || d[10:9] == 2'h3) ? 2'h0 : d[10:9],
          "adc gain");
      chk(scale_q, d[8:0], "scale");
      chk(step_q, d[11] ? STEP_HALF_NV : STEP_UNITY_NV, "step");
      rd(5);
    end
    // Target path under both amp gains, random modes and floors
    for (int a = 0; a < 2; a++) begin
      wr(5, {4'h0, 1'(a), 11'h020});
      idle();
      for (int n = 0; n < 16; n++) begin
        @(posedge ref_clk);
        op_mode <= 2'($random(seed));
        nominal_vid <= 9'($random(seed));
        floor_vid <= 9'($random(seed)) >> 1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(vref_target_q, tgt(op_mode, nominal_vid, floor_vid),
            "target");
      end
    end
    idle();
    repeat (3) @(negedge ref_clk);
    // Mid-run reset brings every bank register back to zero and the step back to unity
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) img[i] = 16'h0000;
    for (int i = 0; i < 6; i++) rd(i);
    @(negedge ref_clk);
    chk(step_q, STEP_UNITY_NV, "step after reset");
    chk(vref_target_q, tgt(op_mode, nominal_vid, floor_vid),
        "target after reset");
    idle();
    repeat (3) @(negedge ref_clk);
    chk(exp_q.size(), 0, "answers missing");
    complete_run();
  end
endmodule : vmr_regs_tb
